// >>> verilog/phy_link_pkg.sv
/*
 * constants, timing counts and state codes shared by both ends of the
 * physical-layer to link-controller power and status link.
 * assumes a single 125 MHz core clock at each end.
 */
package phy_link_pkg;

    // ------------------------------------------------------------
    // clock
    // ------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 8;

    // ------------------------------------------------------------
    // power sense timing, low-time limits counted in system clock cycles, sense pulse lengths in core clock cycles
    // ------------------------------------------------------------
    localparam int             LOW_CNT_W        = 11;
    localparam logic [10:0]    SCLK_INACTIVE_CYC = 11'h080;
    localparam logic [10:0]    SCLK_DISABLE_CYC  = 11'h500;
    localparam logic [10:0]    LOW_CNT_SAT       = 11'h501;
    localparam int             SENSE_MIN_NS      = 21;
    localparam int             SENSE_MIN_CYC     =
        (SENSE_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [3:0]     SENSE_HIGH_CYC    = 4'(SENSE_MIN_CYC);
    localparam logic [3:0]     SENSE_LOW_CYC     = 4'hf;

    // ------------------------------------------------------------
    // hardware reset pin, request and reset hold, line rate, wake output and sclk watch
    // ------------------------------------------------------------
    localparam logic [1:0]     HW_RESET_SCLK     = 2'h2;
    localparam logic [3:0]     RESET_HOLD_CYC    = 4'hc;
    localparam logic [3:0]     REQ_HOLD_CYC      = 4'h8;
    localparam logic [1:0]     HALF_FAST         = 2'h0;
    localparam logic [1:0]     HALF_SLOW         = 2'h1;
    localparam logic [3:0]     WAKE_HALF_CYC     = 4'h9;
    localparam logic [3:0]     SCLK_WATCH_CYC    = 4'hf;

    // ------------------------------------------------------------
    // link interface states
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        ST_ACTIVE   = 3'b001,
        ST_IGNORE   = 3'b010,
        ST_DISABLED = 3'b100
    } link_state_e;

endpackage : phy_link_pkg

// >>> verilog/phy_link_if.sv
/*
 * pin-level link between the physical-layer end and the link controller.
 * assumes both ends share core_clk; every signal is a plain level.
 */
`timescale 1ns/1ps
interface phy_link_if;
    logic sclk;
    logic link_power_sense;
    logic link_request_in;
    logic reset_n;
    logic link_wake_out;
    logic manufacturing_test;
    logic scan_test;
    logic powerdown_test_in;
    logic invert_line_polarity;
    logic line_rate_select;

    modport phy (
        output sclk,
        output link_wake_out,
        input  link_power_sense,
        input  link_request_in,
        input  reset_n,
        input  manufacturing_test,
        input  scan_test,
        input  powerdown_test_in,
        input  invert_line_polarity,
        input  line_rate_select
    );

    modport link (
        input  sclk,
        input  link_wake_out,
        output link_power_sense,
        output link_request_in,
        output reset_n,
        output manufacturing_test,
        output scan_test,
        output powerdown_test_in,
        output invert_line_polarity,
        output line_rate_select
    );
endinterface : phy_link_if

// >>> verilog/phy_power_monitor.sv
/*
 * physical-layer end: system clock generation, power sense judgement,
 * link interface state, reset pin, wake output and line pin polarity.
 * assumes link pins arrive asynchronously and are synchronised here.
 */
`timescale 1ns/1ps
module phy_power_monitor (
    input  wire logic  core_clk,
    input  wire logic  reset,
    phy_link_if.phy    lnk,
    input  wire logic  rx_line_data,
    input  wire logic  rx_line_strobe,
    input  wire logic  tx_data_in,
    input  wire logic  tx_strobe_in,
    input  wire logic  tx_drive_en,
    input  wire logic  tx_tristate_en,
    input  wire logic  wake_request,
    input  wire logic  bus_reset,
    output logic       tx_line_data,
    output logic       tx_line_strobe,
    output logic       open_collector_drive_enable_n,
    output logic       tristate_drive_enable_n,
    output logic       rx_data_out,
    output logic       rx_strobe_out,
    output logic       link_active,
    output logic       request_taken,
    output logic       interface_disabled,
    output logic       test_mode_seen
);

    // ------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------
    logic [6:0] sync1_q;
    logic [6:0] sync2_q;
    logic [6:0] pins_in;
    assign pins_in = {lnk.link_power_sense, lnk.link_request_in, lnk.reset_n,
                      lnk.manufacturing_test | lnk.scan_test | lnk.powerdown_test_in,
                      lnk.invert_line_polarity, lnk.line_rate_select, 1'b0};

    always_ff @(posedge core_clk) begin
        if (reset) begin
            sync1_q <= 7'h10;
            sync2_q <= 7'h10;
        end else begin
            sync1_q <= pins_in;
            sync2_q <= sync1_q;
        end
    end

    logic sense_s;
    logic req_s;
    logic rst_n_s;
    logic test_s;
    logic inv_s;
    logic rate_s;
    assign sense_s = sync2_q[6];
    assign req_s   = sync2_q[5];
    assign rst_n_s = sync2_q[4];
    assign test_s  = sync2_q[3];
    assign inv_s   = sync2_q[2];
    assign rate_s  = sync2_q[1];

    always_ff @(posedge core_clk) begin
        if (reset) test_mode_seen <= 1'b0;
        else       test_mode_seen <= test_s;
    end

    // ------------------------------------------------------------
    // system clock divider
    // ------------------------------------------------------------
    logic [1:0] div_q;
    logic       sclk_q;
    logic       half_tick;
    logic       sclk_tick;
    logic [1:0] half_len;

    assign half_len  = rate_s ? phy_link_pkg::HALF_SLOW : phy_link_pkg::HALF_FAST;
    assign half_tick = (div_q >= half_len);
    assign sclk_tick = half_tick && !sclk_q;

    always_ff @(posedge core_clk) begin
        if (reset) begin
            div_q  <= 2'h0;
            sclk_q <= 1'b0;
        end else if (half_tick) begin
            div_q  <= 2'h0;
            sclk_q <= ~sclk_q;
        end else begin
            div_q  <= div_q + 2'h1;
        end
    end

    // ------------------------------------------------------------
    // hardware reset pin
    // ------------------------------------------------------------
    logic [1:0] rst_cnt_q;
    logic       hw_reset;
    assign hw_reset = sclk_tick && !rst_n_s && (rst_cnt_q == phy_link_pkg::HW_RESET_SCLK - 2'h1);

    always_ff @(posedge core_clk) begin
        if (reset)                     rst_cnt_q <= 2'h0;
        else if (rst_n_s)              rst_cnt_q <= 2'h0;
        else if (sclk_tick && rst_cnt_q != phy_link_pkg::HW_RESET_SCLK)
            rst_cnt_q <= rst_cnt_q + 2'h1;
    end

    // ------------------------------------------------------------
    // power sense low-time count
    // ------------------------------------------------------------
    logic [phy_link_pkg::LOW_CNT_W-1:0] low_cnt_q;
    logic                               sense_active;
    logic                               sense_dead;

    always_ff @(posedge core_clk) begin
        if (reset) begin
            low_cnt_q <= phy_link_pkg::LOW_CNT_SAT;
        end else if (hw_reset) begin
            low_cnt_q <= phy_link_pkg::LOW_CNT_SAT;
        end else if (sclk_tick) begin
            if (sense_s)
                low_cnt_q <= '0;
            else if (low_cnt_q != phy_link_pkg::LOW_CNT_SAT)
                low_cnt_q <= low_cnt_q + 11'h001;
        end
    end

    assign sense_active = (low_cnt_q <= phy_link_pkg::SCLK_INACTIVE_CYC);
    assign sense_dead   = (low_cnt_q > phy_link_pkg::SCLK_DISABLE_CYC);

    // ------------------------------------------------------------
    // link interface state
    // ------------------------------------------------------------
    phy_link_pkg::link_state_e state_q;

    always_ff @(posedge core_clk) begin
        if (reset) begin
            state_q <= phy_link_pkg::ST_DISABLED;
        end else if (hw_reset) begin
            state_q <= phy_link_pkg::ST_DISABLED;
        end else begin
            case (state_q)
                phy_link_pkg::ST_ACTIVE: begin
                    if (!sense_active) state_q <= phy_link_pkg::ST_IGNORE;
                end
                phy_link_pkg::ST_IGNORE: begin
                    if (sense_dead)        state_q <= phy_link_pkg::ST_DISABLED;
                    else if (sense_active) state_q <= phy_link_pkg::ST_ACTIVE;
                end
                phy_link_pkg::ST_DISABLED: begin
                    if (sense_active) state_q <= phy_link_pkg::ST_ACTIVE;
                end
                default: state_q <= phy_link_pkg::ST_DISABLED;
            endcase
        end
    end

    assign link_active        = (state_q == phy_link_pkg::ST_ACTIVE);
    assign interface_disabled = (state_q == phy_link_pkg::ST_DISABLED);

    // clock output held low only while disabled
    logic sclk_out_q;
    always_ff @(posedge core_clk) begin
        if (reset) sclk_out_q <= 1'b0;
        else       sclk_out_q <= half_tick ? ~sclk_q & !interface_disabled
                                           : sclk_q & !interface_disabled;
    end
    assign lnk.sclk = sclk_out_q;

    // ------------------------------------------------------------
    // link request
    // ------------------------------------------------------------
    logic req_prev_q;
    always_ff @(posedge core_clk) begin
        if (reset) begin
            req_prev_q    <= 1'b0;
            request_taken <= 1'b0;
        end else begin
            req_prev_q    <= req_s;
            request_taken <= req_s && !req_prev_q && link_active;
        end
    end

    // ------------------------------------------------------------
    // wake output
    // ------------------------------------------------------------
    logic       wake_on_q;
    logic       wake_sq_q;
    logic [3:0] wake_div_q;

    always_ff @(posedge core_clk) begin
        if (reset)                          wake_on_q <= 1'b0;
        else if (bus_reset || sense_active) wake_on_q <= 1'b0;
        else if (wake_request)              wake_on_q <= 1'b1;
    end

    always_ff @(posedge core_clk) begin
        if (reset || !wake_on_q) begin
            wake_div_q <= 4'h0;
            wake_sq_q  <= 1'b0;
        end else if (wake_div_q == phy_link_pkg::WAKE_HALF_CYC) begin
            wake_div_q <= 4'h0;
            wake_sq_q  <= ~wake_sq_q;
        end else begin
            wake_div_q <= wake_div_q + 4'h1;
        end
    end
    assign lnk.link_wake_out = wake_sq_q;

    // ------------------------------------------------------------
    // line pins
    // ------------------------------------------------------------
    logic [1:0] rx1_q;
    logic [1:0] rx2_q;

    always_ff @(posedge core_clk) begin
        if (reset) begin
            rx1_q         <= 2'h0;
            rx2_q         <= 2'h0;
            rx_data_out   <= 1'b0;
            rx_strobe_out <= 1'b0;
        end else begin
            rx1_q <= {rx_line_data, rx_line_strobe};
            rx2_q <= rx1_q;
            if (half_tick) begin
                rx_data_out   <= rx2_q[1] ^ inv_s;
                rx_strobe_out <= rx2_q[0] ^ inv_s;
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (reset) begin
            tx_line_data                  <= 1'b0;
            tx_line_strobe                <= 1'b0;
            open_collector_drive_enable_n <= 1'b1;
            tristate_drive_enable_n       <= 1'b1;
        end else begin
            tx_line_data                  <= tx_data_in ^ inv_s;
            tx_line_strobe                <= tx_strobe_in ^ inv_s;
            open_collector_drive_enable_n <= ~tx_drive_en ^ inv_s;
            tristate_drive_enable_n       <= ~tx_tristate_en ^ inv_s;
        end
    end

endmodule : phy_power_monitor

// >>> verilog/link_controller_end.sv
/*
 * link controller end: drives power sense pulses, service requests,
 * the reset pin, test pins and line configuration toward the phy.
 * assumes sclk and the wake pin arrive asynchronously.
 */
`timescale 1ns/1ps
module link_controller_end (
    input  wire logic  core_clk,
    input  wire logic  reset,
    phy_link_if.link   lnk,
    input  wire logic  powered,
    input  wire logic  request,
    input  wire logic  hw_reset_req,
    input  wire logic  invert_cfg,
    input  wire logic  slow_rate_cfg,
    output logic       busy,
    output logic       wake_seen,
    output logic       sclk_running
);

    // ------------------------------------------------------------
    // power sense pulse train
    // ------------------------------------------------------------
    logic [3:0] sense_cnt_q;
    logic       sense_q;

    always_ff @(posedge core_clk) begin
        if (reset || !powered) begin
            sense_cnt_q <= 4'h0;
            sense_q     <= 1'b0;
        end else if (sense_q && sense_cnt_q == phy_link_pkg::SENSE_HIGH_CYC - 4'h1) begin
            sense_cnt_q <= 4'h0;
            sense_q     <= 1'b0;
        end else if (!sense_q && sense_cnt_q == phy_link_pkg::SENSE_LOW_CYC) begin
            sense_cnt_q <= 4'h0;
            sense_q     <= 1'b1;
        end else begin
            sense_cnt_q <= sense_cnt_q + 4'h1;
        end
    end
    assign lnk.link_power_sense = sense_q;

    // ------------------------------------------------------------
    // request and reset pulses
    // ------------------------------------------------------------
    logic [3:0] req_cnt_q;
    logic [3:0] rst_cnt_q;

    always_ff @(posedge core_clk) begin
        if (reset)                    req_cnt_q <= 4'h0;
        else if (req_cnt_q != 4'h0)   req_cnt_q <= req_cnt_q - 4'h1;
        else if (request)             req_cnt_q <= phy_link_pkg::REQ_HOLD_CYC;
    end

    always_ff @(posedge core_clk) begin
        if (reset)                    rst_cnt_q <= 4'h0;
        else if (rst_cnt_q != 4'h0)   rst_cnt_q <= rst_cnt_q - 4'h1;
        else if (hw_reset_req)        rst_cnt_q <= phy_link_pkg::RESET_HOLD_CYC;
    end

    assign busy                     = (req_cnt_q != 4'h0) || (rst_cnt_q != 4'h0);
    assign lnk.link_request_in      = (req_cnt_q != 4'h0);
    assign lnk.reset_n              = (rst_cnt_q == 4'h0);
    assign lnk.manufacturing_test   = 1'b0;
    assign lnk.scan_test            = 1'b0;
    assign lnk.powerdown_test_in    = 1'b0;
    assign lnk.invert_line_polarity = invert_cfg;
    assign lnk.line_rate_select     = slow_rate_cfg;

    // ------------------------------------------------------------
    // observe phy clock and wake
    // ------------------------------------------------------------
    logic [1:0] s1_q;
    logic [1:0] s2_q;
    logic       sclk_prev_q;
    logic [3:0] watch_q;

    always_ff @(posedge core_clk) begin
        if (reset) begin
            s1_q        <= 2'h0;
            s2_q        <= 2'h0;
            sclk_prev_q <= 1'b0;
            watch_q     <= 4'h0;
            wake_seen   <= 1'b0;
        end else begin
            s1_q        <= {lnk.sclk, lnk.link_wake_out};
            s2_q        <= s1_q;
            sclk_prev_q <= s2_q[1];
            wake_seen   <= s2_q[0];
            if (s2_q[1] != sclk_prev_q) watch_q <= phy_link_pkg::SCLK_WATCH_CYC;
            else if (watch_q != 4'h0)   watch_q <= watch_q - 4'h1;
        end
    end
    assign sclk_running = (watch_q != 4'h0);

endmodule : link_controller_end

// >>> testbench/phy_link_props.sv
/* checker for the phy to link-controller power and status wires.
   assumes the signals of phy_link_if and one 125 MHz core clock. */
`timescale 1ns/1ps
module phy_link_props (
    input logic core_clk,
    input logic reset,
    input logic sclk,
    input logic link_power_sense,
    input logic link_request_in,
    input logic reset_n,
    input logic link_wake_out,
    input logic manufacturing_test,
    input logic scan_test,
    input logic powerdown_test_in,
    input logic invert_line_polarity,
    input logic line_rate_select
);
    logic [12:0] low_cnt_q;
    logic        rate_q;
    logic [3:0]  rate_age_q;
    logic        steady;

    default clocking @(posedge core_clk); endclocking
    default disable iff (reset);

    // --------------------------------
    // cycles since sense was last high
    // --------------------------------
    always_ff @(posedge core_clk) begin
        if (reset) low_cnt_q <= 13'h1fff;
        else if (link_power_sense) low_cnt_q <= 13'h0000;
        else if (low_cnt_q != 13'h1fff) low_cnt_q <= low_cnt_q + 13'h0001;
    end

    always_ff @(posedge core_clk) begin
        rate_q <= line_rate_select;
        if (reset || rate_q != line_rate_select) rate_age_q <= 4'h0;
        else if (rate_age_q != 4'hf) rate_age_q <= rate_age_q + 4'h1;
    end
    assign steady = (rate_age_q == 4'hf);

    // --------------------------------
    // assertions
    // --------------------------------
    a_fast_sclk_half: assert property (
        $rose(sclk) && !line_rate_select && steady |=> !sclk)
        else $error("fast sclk high longer than one cycle");
    a_slow_sclk_half: assert property (
        $rose(sclk) && line_rate_select && steady && reset_n && low_cnt_q < 13'h0fa0
        |=> sclk ##1 !sclk)
        else $error("slow sclk high phase not two cycles");
    a_idle_sclk_runs: assert property (
        low_cnt_q >= 13'h012c && low_cnt_q <= 13'h0960 && !line_rate_select && steady
        && reset_n |-> sclk != $past(sclk))
        else $error("sclk stopped while only idle");
    a_long_low_stops: assert property (
        low_cnt_q >= 13'h1518 |-> !sclk)
        else $error("sclk runs after long low sense");
    a_hw_reset_stops: assert property (
        $fell(reset_n) |-> ##[2:16] !sclk [*3])
        else $error("sclk not stopped by hardware reset");
    a_reset_pulse_len: assert property (
        $fell(reset_n) |-> !reset_n [*4])
        else $error("reset pin pulse too short");
    a_request_hold: assert property (
        $rose(link_request_in) |-> link_request_in [*8] ##1 !link_request_in)
        else $error("request pin not held eight cycles");
    a_test_pins_low: assert property (
        !(manufacturing_test || scan_test || powerdown_test_in))
        else $error("test pin driven high");
    a_wake_cleared: assert property (
        $rose(link_power_sense) |-> ##[1:10] !link_wake_out [*8])
        else $error("wake not cleared by active sense");

    c_request: cover property ($rose(link_request_in));
    c_wake: cover property ($rose(link_wake_out));
    c_disabled: cover property (low_cnt_q == 13'h0a28);
    c_hw_reset: cover property ($fell(reset_n));
endmodule : phy_link_props

// >>> testbench/link_power_status_monitor_test.sv
/* testbench: both ends joined by phy_link_if, user sides driven here.
   assumes 125 MHz core_clk and synchronous active-high reset. */
`timescale 1ns/1ps
module link_power_status_monitor_test;
    logic core_clk, reset, rx_line_data, rx_line_strobe, tx_data_in;
    logic tx_strobe_in, tx_drive_en, tx_tristate_en, wake_request, bus_reset;
    logic powered, request, hw_reset_req, invert_cfg, slow_rate_cfg;
    logic tx_line_data, tx_line_strobe, open_collector_drive_enable_n;
    logic tristate_drive_enable_n, rx_data_out, rx_strobe_out, link_active;
    logic request_taken, interface_disabled, test_mode_seen, busy, wake_seen;
    logic sclk_running;
    int   failures, checks, seed;
    logic exp_q[$];

    phy_link_if lnk ();
    phy_power_monitor phy_power_monitor_i (.core_clk, .reset, .lnk(lnk),
        .rx_line_data, .rx_line_strobe, .tx_data_in, .tx_strobe_in, .tx_drive_en,
        .tx_tristate_en, .wake_request, .bus_reset, .tx_line_data, .tx_line_strobe,
        .open_collector_drive_enable_n, .tristate_drive_enable_n, .rx_data_out,
        .rx_strobe_out, .link_active, .request_taken, .interface_disabled, .test_mode_seen);
    link_controller_end link_controller_end_i (.core_clk, .reset, .lnk(lnk), .powered,
        .request, .hw_reset_req, .invert_cfg, .slow_rate_cfg, .busy, .wake_seen,
        .sclk_running);
    phy_link_props phy_link_props_i (.core_clk, .reset, .sclk(lnk.sclk),
        .link_power_sense(lnk.link_power_sense), .link_request_in(lnk.link_request_in),
        .reset_n(lnk.reset_n), .link_wake_out(lnk.link_wake_out),
        .manufacturing_test(lnk.manufacturing_test), .scan_test(lnk.scan_test),
        .powerdown_test_in(lnk.powerdown_test_in),
        .invert_line_polarity(lnk.invert_line_polarity),
        .line_rate_select(lnk.line_rate_select));

    initial begin
        core_clk = 1'b0;
        forever #4 core_clk = ~core_clk;
    end

    // --------------------------------
    // shared tasks
    // --------------------------------
    task automatic tick(input int k);
        repeat (k) @(posedge core_clk);
        #1;
    endtask : tick

    task automatic check(input logic got, input logic exp, input string what);
        checks++;
        if (got !== exp) begin
            failures++;
            $display("unexpected at %0t: %s", $time, what);
        end
    endtask : check

    task automatic give_verdict();
        $display("checks %0d failures %0d", checks, failures);
        if (failures == 0 && checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : give_verdict

    function automatic logic probe(input int sel);
        case (sel)
            0: return link_active;
            1: return interface_disabled;
            2: return wake_seen;
            default: return busy;
        endcase
    endfunction : probe

    task automatic wait_for(input int sel, input logic val, input int lim);
        for (int i = 0; i < lim && probe(sel) !== val; i++) begin
            tick(1);
        end
        check(probe(sel), val, "wait ran out");
        if (probe(sel) !== val) give_verdict();
    endtask : wait_for

    task automatic pulse(ref logic sig);
        sig = 1'b1;
        tick(1);
        sig = 1'b0;
    endtask : pulse

    task automatic send_request(input logic taken);
        if (taken) exp_q.push_back(1'b1);
        pulse(request);
        wait_for(3, 1'b0, 40);
    endtask : send_request

    // --------------------------------
    // result watcher
    // --------------------------------
    always @(posedge core_clk) begin
        if (!reset && request_taken === 1'b1) begin
            if (exp_q.size() == 0) check(1'b1, 1'b0, "request taken while idle");
            else check(link_active, exp_q.pop_front(), "request taken");
        end
    end

    // --------------------------------
    // main sequence
    // --------------------------------
    initial begin
        seed = 13;
        failures = 0;
        checks = 0;
        reset = 1'b1;
        {rx_line_data, rx_line_strobe, tx_data_in, tx_strobe_in} = 4'h0;
        {tx_drive_en, tx_tristate_en, wake_request, bus_reset} = 4'h0;
        {powered, request, hw_reset_req, invert_cfg, slow_rate_cfg} = 5'h00;
        tick(4);
        reset = 1'b0;
        tick(3);
        check(interface_disabled, 1'b1, "not disabled after reset");
        check(sclk_running, 1'b0, "sclk runs after reset");
        powered = 1'b1;
        wait_for(0, 1'b1, 200);
        for (int m = 0; m < 4; m++) begin
            invert_cfg = m[0];
            slow_rate_cfg = m[1];
            for (int k = 0; k < 6; k++) begin
                {rx_line_data, rx_line_strobe, tx_data_in, tx_strobe_in, tx_drive_en,
                 tx_tristate_en} = 6'($random(seed));
                tick(10);
                check(tx_line_data, tx_data_in ^ m[0], "tx data");
                check(tx_line_strobe, tx_strobe_in ^ m[0], "tx strobe");
                check(open_collector_drive_enable_n, ~tx_drive_en ^ m[0], "oc");
                check(tristate_drive_enable_n, ~tx_tristate_en ^ m[0], "tri");
                check(rx_data_out, rx_line_data ^ m[0], "rx data");
                check(rx_strobe_out, rx_line_strobe ^ m[0], "rx strobe");
            end
            check(sclk_running, 1'b1, "sclk stopped");
            send_request(1'b1);
        end
        powered = 1'b0;
        slow_rate_cfg = 1'b0;
        tick(240);
        check(link_active, 1'b1, "inactive too early");
        tick(80);
        check(link_active, 1'b0, "still active");
        check(sclk_running, 1'b1, "sclk stopped while idle");
        send_request(1'b0);
        pulse(wake_request);
        wait_for(2, 1'b1, 60);
        pulse(bus_reset);
        tick(25);
        check(wake_seen, 1'b0, "wake kept after bus reset");
        tick(10);
        check(wake_seen, 1'b0, "wake kept after bus reset");
        pulse(wake_request);
        wait_for(2, 1'b1, 60);
        powered = 1'b1;
        wait_for(0, 1'b1, 200);
        tick(25);
        check(wake_seen, 1'b0, "wake kept while active");
        powered = 1'b0;
        tick(2400);
        check(interface_disabled, 1'b0, "disabled too early");
        tick(300);
        check(interface_disabled, 1'b1, "not disabled");
        check(sclk_running, 1'b0, "sclk runs when disabled");
        powered = 1'b1;
        wait_for(0, 1'b1, 200);
        send_request(1'b1);
        pulse(hw_reset_req);
        wait_for(1, 1'b1, 40);
        wait_for(0, 1'b1, 200);
        check(test_mode_seen, 1'b0, "test mode seen");
        check(exp_q.size() == 0, 1'b1, "request not taken");
        give_verdict();
    end
endmodule : link_power_status_monitor_test
